// File: rtl/cpu_side_control.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_side_control
   import cpu_side_pkg::*;
#(
   parameter logic [RESET_CNT_W-1:0] PROC_CLKS = RESET_PROC_CLKS
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic parity_error_in,
   input wire logic channel_error_in,
   input wire logic [IO_ADDR_W-1:0] io_addr,
   input wire logic [IO_DATA_W-1:0] io_wdata,
   input wire logic io_write,
   input wire logic io_read,
   input wire logic cycle_done_req,
   input wire logic shutdown_cycle,
   input wire logic supply_good_in,
   input wire logic processor_clock_in,
   input wire logic double_freq_clock_in,
   input wire logic bus_grant_ack,
   input wire logic rdy_n_in,
   output logic rdy_n_out,
   output logic rdy_n_oe,
   output logic nmi_out,
   output logic processor_reset_out,
   output logic system_clock_out,
   output logic local_cycle_end
);
   logic nmi_enable_r;
   logic nmi_cause;
   logic pclk_prev_r;
   logic proc_clk_en;
   logic sg_prev_r;
   logic sg_valid_r;
   logic sg_change;
   logic ef_read;
   logic port_a_reset;
   logic reset_trigger;
   logic reset_busy;
   logic done_pending_r;
   rdy_state_e rdy_state_r;
   rdy_state_e rdy_state_nxt;

   // =====================================================
   // processor clock edge, used as the cpu clock enable
   always_ff @(posedge clk) begin
      if (srst) begin
         pclk_prev_r <= 1'b1; // a clock already high at release gives no false edge
      end else begin
         pclk_prev_r <= processor_clock_in;
      end
   end

   assign proc_clk_en = processor_clock_in & ~pclk_prev_r;

   // =====================================================
   // nmi mask: port 70h bit 7 set blocks nmi, clear allows it
   always_ff @(posedge clk) begin
      if (srst) begin
         nmi_enable_r <= NMI_ENABLE_RST;
      end else if (io_write && io_addr == NMI_PORT_ADDR) begin
         nmi_enable_r <= ~io_wdata[NMI_MASK_BIT];
      end
   end

   assign nmi_cause = parity_error_in | channel_error_in;

   // nmi follows the error level; sources hold their error until serviced
   always_ff @(posedge clk) begin
      if (srst) begin
         nmi_out <= 1'b0;
      end else begin
         nmi_out <= nmi_enable_r & nmi_cause;
      end
   end

   // =====================================================
   // reset sources
   assign ef_read = io_read && (io_addr == RESET_PORT_ADDR);
   assign port_a_reset = io_write && (io_addr == PORT_A_ADDR) &&
      io_wdata[PORT_A_RESET_BIT];

   // supply level is caught after release, so no edge is faked at start-up
   always_ff @(posedge clk) begin
      if (srst) begin
         sg_prev_r <= 1'b0;
         sg_valid_r <= 1'b0;
      end else begin
         sg_prev_r <= supply_good_in;
         sg_valid_r <= 1'b1;
      end
   end

   assign sg_change = sg_valid_r && (supply_good_in != sg_prev_r);
   assign reset_trigger = ef_read | port_a_reset | sg_change | shutdown_cycle;

   reset_stretcher #(
      .PROC_CLKS(PROC_CLKS)
   ) u_reset (
      .clk(clk),
      .srst(srst),
      .trigger(reset_trigger),
      .proc_clk_en(proc_clk_en),
      .processor_reset_out(processor_reset_out),
      .busy(reset_busy)
   );

   // =====================================================
   // system clock from the double frequency input
   freq_halver u_halver (
      .clk(clk),
      .srst(srst),
      .double_freq_clock_in(double_freq_clock_in),
      .system_clock_out(system_clock_out)
   );

   // =====================================================
   // cycle done request latch; a new request in the take-up cycle wins
   always_ff @(posedge clk) begin
      if (srst) begin
         done_pending_r <= 1'b0;
      end else if (cycle_done_req && !bus_grant_ack) begin
         done_pending_r <= 1'b1;
      end else if (bus_grant_ack) begin
         done_pending_r <= 1'b0; // slot cycles do not finish under grant
      end else if (proc_clk_en && rdy_state_r == RDY_IDLE) begin
         done_pending_r <= 1'b0;
      end
   end

   // ready sequencer: low for one cpu clock, then high for one, then off
   always_comb begin
      rdy_state_nxt = rdy_state_r;
      case (rdy_state_r)
         RDY_IDLE: begin
            if (proc_clk_en && done_pending_r && !bus_grant_ack) begin
               rdy_state_nxt = RDY_LOW;
            end
         end
         RDY_LOW: begin
            if (bus_grant_ack) begin
               rdy_state_nxt = RDY_IDLE;
            end else if (proc_clk_en) begin
               rdy_state_nxt = RDY_HIGH;
            end
         end
         RDY_HIGH: begin
            if (bus_grant_ack || proc_clk_en) begin
               rdy_state_nxt = RDY_IDLE;
            end
         end
         default: begin
            rdy_state_nxt = RDY_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdy_state_r <= RDY_IDLE;
      end else begin
         rdy_state_r <= rdy_state_nxt;
      end
   end

   // driver released at once under grant, so two masters never fight
   assign rdy_n_oe = (rdy_state_r != RDY_IDLE) && !bus_grant_ack;
   assign rdy_n_out = (rdy_state_r != RDY_LOW);

   // under grant the line is an input ending dma and master cycles
   always_ff @(posedge clk) begin
      if (srst) begin
         local_cycle_end <= 1'b0;
      end else begin
         local_cycle_end <= bus_grant_ack && !rdy_n_in;
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   property p_nmi_raise;
      (nmi_enable_r && nmi_cause) |=> nmi_out;
   endproperty
   a_nmi_raise: assert property (p_nmi_raise)
      else $error("nmi missed an enabled error");

   property p_nmi_mask;
      !nmi_enable_r |=> !nmi_out;
   endproperty
   a_nmi_mask: assert property (p_nmi_mask)
      else $error("nmi raised while masked");

   property p_nmi_port;
      (io_write && io_addr == NMI_PORT_ADDR && io_wdata[NMI_MASK_BIT] && nmi_cause)
         |=> ##1 !nmi_out;
   endproperty
   a_nmi_port: assert property (p_nmi_port)
      else $error("port 70h mask bit did not block nmi");

   property p_rdy_low;
      (rdy_n_oe && !rdy_n_out) |-> (rdy_state_r == RDY_LOW) && !bus_grant_ack;
   endproperty
   a_rdy_low: assert property (p_rdy_low)
      else $error("ready driven low outside its phase");

   property p_rdy_start;
      (proc_clk_en && done_pending_r && !bus_grant_ack && rdy_state_r == RDY_IDLE)
         |=> (rdy_n_oe || bus_grant_ack) && !rdy_n_out;
   endproperty
   a_rdy_start: assert property (p_rdy_start)
      else $error("cycle done not signalled");

   property p_rdy_release;
      (rdy_state_r == RDY_HIGH && proc_clk_en) |=> !rdy_n_oe;
   endproperty
   a_rdy_release: assert property (p_rdy_release)
      else $error("ready driver kept on past one cpu clock high");

   property p_rdy_high_follows;
      (rdy_state_r == RDY_LOW && proc_clk_en && !bus_grant_ack)
         |=> (rdy_n_out && (rdy_n_oe || bus_grant_ack));
   endproperty
   a_rdy_high_follows: assert property (p_rdy_high_follows)
      else $error("ready not driven high after low");

   property p_grant_input;
      bus_grant_ack |-> !rdy_n_oe;
   endproperty
   a_grant_input: assert property (p_grant_input)
      else $error("ready driven while bus granted");

   property p_local_end;
      (bus_grant_ack && !rdy_n_in) |=> local_cycle_end;
   endproperty
   a_local_end: assert property (p_local_end)
      else $error("local cycle end lost");

   property p_reset_trig;
      (ef_read || port_a_reset) |=> reset_busy;
   endproperty
   a_reset_trig: assert property (p_reset_trig)
      else $error("port access did not start processor reset");

   property p_reset_other;
      (sg_change || shutdown_cycle) |=> reset_busy;
   endproperty
   a_reset_other: assert property (p_reset_other)
      else $error("supply change or shutdown did not start processor reset");

   // =====================================================
   // phase lengths, quiet outputs and grant hand-over
   property p_nmi_quiet;
      !nmi_cause |=> !nmi_out;
   endproperty
   a_nmi_quiet: assert property (p_nmi_quiet)
      else $error("nmi raised with no error present");

   property p_nmi_unmask;
      (io_write && io_addr == NMI_PORT_ADDR && !io_wdata[NMI_MASK_BIT]) |=> nmi_enable_r;
   endproperty
   a_nmi_unmask: assert property (p_nmi_unmask)
      else $error("clear mask bit did not allow nmi");

   property p_rdy_no_start;
      (rdy_state_r == RDY_IDLE && !(proc_clk_en && done_pending_r)) |=> !rdy_n_oe;
   endproperty
   a_rdy_no_start: assert property (p_rdy_no_start)
      else $error("ready driver turned on with nothing to end");

   property p_rdy_low_hold;
      (rdy_state_r == RDY_LOW && !proc_clk_en && !bus_grant_ack)
         |=> (rdy_state_r == RDY_LOW);
   endproperty
   a_rdy_low_hold: assert property (p_rdy_low_hold)
      else $error("ready low phase cut short");

   property p_rdy_high_hold;
      (rdy_state_r == RDY_HIGH && !proc_clk_en && !bus_grant_ack)
         |=> (rdy_state_r == RDY_HIGH);
   endproperty
   a_rdy_high_hold: assert property (p_rdy_high_hold)
      else $error("ready high phase cut short");

   property p_done_drop;
      bus_grant_ack |=> !done_pending_r;
   endproperty
   a_done_drop: assert property (p_done_drop)
      else $error("slot cycle end kept under bus grant");

   property p_local_quiet;
      !bus_grant_ack |=> !local_cycle_end;
   endproperty
   a_local_quiet: assert property (p_local_quiet)
      else $error("local cycle end without bus grant");

   c_nmi: cover property (nmi_out);
   c_rdy_seq: cover property ((rdy_state_r == RDY_LOW) ##[1:20] (rdy_state_r == RDY_HIGH));
   c_rdy_release: cover property ((rdy_state_r == RDY_HIGH) ##1 (rdy_state_r == RDY_IDLE));
   c_reset: cover property ($rose(processor_reset_out));
   c_local: cover property (local_cycle_end);
endmodule
`default_nettype wire

// File: common/cpu_side_pkg.sv
// Behaviour
// - the nmi output rises when a memory parity error or an io channel error is seen.
// - the nmi output is allowed only while bit 7 of io port 70h is clear, and reset blocks it.
// - the block pulls the ready line low to end the current memory or io slot cycle.
// - the ready driver is on only while pulling low and for one cpu clock after driving high.
// - under bus grant the ready line is an input that local devices pull low to end cycles.
// - the processor reset output is active high and changes only on a processor clock edge.
// - a read of io port EFh, whose data is meaningless, resets the processor.
// - a write that sets bit 0 of system control port A resets the processor.
// - a level change of the supply good input, or a shutdown cycle, resets the processor.
// - the double frequency clock input is halved to form the system clock output.
package cpu_side_pkg;
   // =====================================================
   // io port map
   localparam int IO_ADDR_W = 16;
   localparam int IO_DATA_W = 8;
   localparam logic [15:0] NMI_PORT_ADDR = 16'h0070;
   localparam int NMI_MASK_BIT = 7;
   localparam logic [15:0] RESET_PORT_ADDR = 16'h00EF;
   localparam logic [15:0] PORT_A_ADDR = 16'h0092;
   localparam int PORT_A_RESET_BIT = 0;
   // =====================================================
   // reset values and timing
   localparam logic NMI_ENABLE_RST = 1'b0;
   localparam logic RESET_PENDING_RST = 1'b1;
   localparam int RESET_CNT_W = 8;
   localparam logic [7:0] RESET_PROC_CLKS = 8'h10;
   localparam int CLK_PERIOD_NS = 40;
   // =====================================================
   // ready driver sequencer
   typedef enum logic [2:0] {
      RDY_IDLE = 3'b001,
      RDY_LOW = 3'b010,
      RDY_HIGH = 3'b100
   } rdy_state_e;
endpackage

// File: rtl/freq_halver.sv
`timescale 1ns/1ns
`default_nettype none
module freq_halver
   import cpu_side_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic double_freq_clock_in,
   output logic system_clock_out
);
   logic dfc_prev_r;
   logic dfc_rise;

   // =====================================================
   // edge of the oversampled input; input must be below half of clk rate
   always_ff @(posedge clk) begin
      if (srst) begin
         dfc_prev_r <= 1'b1; // no false toggle if the oscillator is high at release
      end else begin
         dfc_prev_r <= double_freq_clock_in;
      end
   end

   assign dfc_rise = double_freq_clock_in & ~dfc_prev_r;

   // one toggle per input rise gives half the input frequency
   always_ff @(posedge clk) begin
      if (srst) begin
         system_clock_out <= 1'b0;
      end else if (dfc_rise) begin
         system_clock_out <= ~system_clock_out;
      end
   end

   // =====================================================
   // checks
   property p_halve;
      @(posedge clk) disable iff (srst)
         dfc_rise |=> (system_clock_out != $past(system_clock_out));
   endproperty
   a_halve: assert property (p_halve)
      else $error("system clock did not toggle on input rise");

   property p_hold;
      @(posedge clk) disable iff (srst)
         !dfc_rise |=> $stable(system_clock_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("system clock toggled without input rise");
endmodule
`default_nettype wire

// File: rtl/reset_stretcher.sv
`timescale 1ns/1ns
`default_nettype none
module reset_stretcher
   import cpu_side_pkg::*;
#(
   parameter logic [RESET_CNT_W-1:0] PROC_CLKS = RESET_PROC_CLKS
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic trigger,
   input wire logic proc_clk_en,
   output logic processor_reset_out,
   output logic busy
);
   logic pending_r;
   logic [RESET_CNT_W-1:0] left_r;
   logic [RESET_CNT_W-1:0] seen_r;

   // =====================================================
   // trigger latch; a trigger in the cycle of the take-up is kept
   always_ff @(posedge clk) begin
      if (srst) begin
         pending_r <= RESET_PENDING_RST; // cpu is reset after system reset
      end else if (trigger) begin
         pending_r <= 1'b1;
      end else if (proc_clk_en) begin
         pending_r <= 1'b0;
      end
   end

   // output only moves on a processor clock edge
   always_ff @(posedge clk) begin
      if (srst) begin
         processor_reset_out <= 1'b0;
         left_r <= '0;
      end else if (proc_clk_en) begin
         if (pending_r) begin
            processor_reset_out <= 1'b1;
            left_r <= PROC_CLKS - 1'b1;
         end else if (processor_reset_out) begin
            if (left_r == '0) begin
               processor_reset_out <= 1'b0;
            end else begin
               left_r <= left_r - 1'b1;
            end
         end
      end
   end

   assign busy = pending_r | processor_reset_out;

   // =====================================================
   // checks; seen_r counts processor clocks with the output high
   always_ff @(posedge clk) begin
      if (srst) begin
         seen_r <= '0;
      end else if (proc_clk_en && pending_r) begin
         seen_r <= '0;
      end else if (proc_clk_en && processor_reset_out) begin
         seen_r <= seen_r + 1'b1;
      end
   end

   property p_length;
      @(posedge clk) disable iff (srst)
         $fell(processor_reset_out) |-> (seen_r == PROC_CLKS);
   endproperty
   a_length: assert property (p_length)
      else $error("processor reset width wrong");

   property p_sync;
      @(posedge clk) disable iff (srst)
         (processor_reset_out != $past(processor_reset_out)) |-> $past(proc_clk_en);
   endproperty
   a_sync: assert property (p_sync)
      else $error("processor reset moved off a processor clock edge");

   property p_take;
      @(posedge clk) disable iff (srst)
         (pending_r && proc_clk_en) |=> processor_reset_out;
   endproperty
   a_take: assert property (p_take)
      else $error("pending reset not taken at processor clock edge");
endmodule
`default_nettype wire

// File: tb/cpu_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// host processor model: cpu clock, oscillator, hold handshake, ready wire
module cpu_host_model (
   input wire logic clk,
   input wire logic hold_req,
   input wire logic local_pull,
   input wire logic rdy_n_out,
   input wire logic rdy_n_oe,
   output logic processor_clock_in,
   output logic double_freq_clock_in,
   output logic bus_grant_ack,
   output wire logic rdy_n_in
);
   int n_edges = 0;

   initial begin
      processor_clock_in = 1'b0;
      double_freq_clock_in = 1'b0;
      bus_grant_ack = 1'b0;
   end

   // clocks lag clk by 1 ns so the sampler never races them
   always @(posedge clk) begin
      #1;
      n_edges = n_edges + 1;
      if (n_edges % 3 == 0) begin
         double_freq_clock_in = ~double_freq_clock_in;
      end
      if (n_edges % 2 == 0) begin
         processor_clock_in = ~processor_clock_in;
         // grant only moves on a cpu clock rise, where it copies hold_req at once
         if (processor_clock_in) begin
            bus_grant_ack = hold_req;
         end
      end
   end

   // pull-up on the wire; a local device may pull it low only under grant
   assign rdy_n_in = (rdy_n_oe ? rdy_n_out : 1'b1) & ~(bus_grant_ack & local_pull);
endmodule
`default_nettype wire

// File: tb/test_cpu_side_control.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// bench: cpu clock is clk/4, so one cpu clock is 4 clk cycles
module test_cpu_side_control
   import cpu_side_pkg::*;
;
   localparam logic [RESET_CNT_W-1:0] PROC_CLKS_TB = 8'h02;
   logic clk, srst, parity_error_in, channel_error_in, io_write, io_read;
   logic [IO_ADDR_W-1:0] io_addr;
   logic [IO_DATA_W-1:0] io_wdata;
   logic cycle_done_req, shutdown_cycle, supply_good_in, hold_req, local_pull;
   logic processor_clock_in, double_freq_clock_in, bus_grant_ack, rdy_n_in;
   logic rdy_n_out, rdy_n_oe, nmi_out, processor_reset_out, system_clock_out;
   logic local_cycle_end;
   int n_errors = 0;
   int samples_checked = 0;

   cpu_side_control #(.PROC_CLKS(PROC_CLKS_TB)) dut_u (
      .clk(clk), .srst(srst), .parity_error_in(parity_error_in),
      .channel_error_in(channel_error_in), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_write(io_write), .io_read(io_read), .cycle_done_req(cycle_done_req),
      .shutdown_cycle(shutdown_cycle), .supply_good_in(supply_good_in),
      .processor_clock_in(processor_clock_in), .double_freq_clock_in(double_freq_clock_in),
      .bus_grant_ack(bus_grant_ack), .rdy_n_in(rdy_n_in), .rdy_n_out(rdy_n_out),
      .rdy_n_oe(rdy_n_oe), .nmi_out(nmi_out), .processor_reset_out(processor_reset_out),
      .system_clock_out(system_clock_out), .local_cycle_end(local_cycle_end));

   cpu_host_model host_u (
      .clk(clk), .hold_req(hold_req), .local_pull(local_pull), .rdy_n_out(rdy_n_out),
      .rdy_n_oe(rdy_n_oe), .processor_clock_in(processor_clock_in),
      .double_freq_clock_in(double_freq_clock_in), .bus_grant_ack(bus_grant_ack),
      .rdy_n_in(rdy_n_in));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // =====================================================
   // shared helpers
   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   // a wait that runs out ends the run at once
   task automatic need(input logic ok, input string msg);
      chk(ok, msg);
      if (ok !== 1'b1) begin
         test_done();
      end
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic io_access(input logic [15:0] addr, input logic [7:0] data, input logic rd);
      io_addr = addr;
      io_wdata = data;
      io_write = ~rd;
      io_read = rd;
      tick();
      io_write = 1'b0;
      io_read = 1'b0;
   endtask

   // waits for a cpu reset pulse and measures it in clk cycles
   task automatic reset_pulse(input logic exp, input string msg);
      int k;
      int w;
      k = 0;
      while (processor_reset_out !== 1'b1 && k < 24) begin
         tick();
         k++;
      end
      if (exp) begin
         need(processor_reset_out === 1'b1, msg);
         w = 0;
         while (processor_reset_out === 1'b1 && w < 200) begin
            tick();
            w++;
         end
         need(w == PROC_CLKS_TB * 4, "cpu reset width");
      end else begin
         chk(processor_reset_out === 1'b0, msg);
      end
      repeat (8) tick();
   endtask

   // =====================================================
   // scenarios
   task automatic t_nmi;
      parity_error_in = 1'b1;
      tick();
      tick();
      chk(nmi_out === 1'b0, "nmi not blocked after reset");
      io_access(NMI_PORT_ADDR, 8'h7F, 1'b0);
      tick();
      tick();
      chk(nmi_out === 1'b1, "nmi from parity");
      parity_error_in = 1'b0;
      channel_error_in = 1'b1;
      tick();
      chk(nmi_out === 1'b1, "nmi from channel error");
      io_access(16'h0071, 8'h80, 1'b0);
      tick();
      tick();
      chk(nmi_out === 1'b1, "other port masked nmi");
      io_access(NMI_PORT_ADDR, 8'h80, 1'b0);
      tick();
      tick();
      chk(nmi_out === 1'b0, "nmi not masked");
      channel_error_in = 1'b0;
   endtask

   task automatic t_triggers;
      logic [7:0] exp_r;
      exp_r = 8'h73;
      for (int i = 0; i < 8; i++) begin
         case (i)
            0: io_access(RESET_PORT_ADDR, 8'h00, 1'b1);
            1: io_access(PORT_A_ADDR, 8'h01, 1'b0);
            2: io_access(PORT_A_ADDR, 8'hFE, 1'b0);
            3: io_access(16'h00EE, 8'h00, 1'b1);
            4: supply_good_in = 1'b0;
            5: supply_good_in = 1'b1;
            6: begin
               shutdown_cycle = 1'b1;
               tick();
               shutdown_cycle = 1'b0;
            end
            default: io_access(16'h0093, 8'h01, 1'b0);
         endcase
         reset_pulse(exp_r[i], "cpu reset trigger");
      end
   endtask

   task automatic t_ready;
      int k;
      cycle_done_req = 1'b1;
      tick();
      cycle_done_req = 1'b0;
      k = 0;
      while (rdy_n_oe !== 1'b1 && k < 16) begin
         tick();
         k++;
      end
      need(rdy_n_oe === 1'b1 && rdy_n_out === 1'b0, "ready never driven");
      chk(rdy_n_in === 1'b0, "ready wire not low");
      // a second request while low is kept and served afterwards
      cycle_done_req = 1'b1;
      tick();
      cycle_done_req = 1'b0;
      k = 1;
      while (rdy_n_oe === 1'b1 && rdy_n_out === 1'b0 && k < 50) begin
         tick();
         k++;
      end
      need(k == 4, "ready low width");
      k = 0;
      while (rdy_n_oe === 1'b1 && rdy_n_out === 1'b1 && k < 50) begin
         tick();
         k++;
      end
      need(k == 4, "driver on after high");
      chk(rdy_n_oe === 1'b0 && rdy_n_in === 1'b1, "driver not released");
      k = 0;
      while (rdy_n_oe !== 1'b1 && k < 16) begin
         tick();
         k++;
      end
      need(rdy_n_oe === 1'b1 && rdy_n_out === 1'b0, "queued request lost");
      repeat (12) tick();
   endtask

   task automatic t_grant;
      int k;
      logic quiet;
      hold_req = 1'b1;
      k = 0;
      while (bus_grant_ack !== 1'b1 && k < 20) begin
         tick();
         k++;
      end
      need(bus_grant_ack === 1'b1, "no grant");
      cycle_done_req = 1'b1;
      tick();
      cycle_done_req = 1'b0;
      local_pull = 1'b1;
      tick();
      chk(local_cycle_end === 1'b1 && rdy_n_oe === 1'b0, "local end missed");
      local_pull = 1'b0;
      tick();
      chk(local_cycle_end === 1'b0, "local end stuck");
      hold_req = 1'b0;
      quiet = 1'b1;
      repeat (24) begin
         tick();
         quiet = quiet & (rdy_n_oe === 1'b0);
      end
      chk(bus_grant_ack === 1'b0 && quiet, "ready driven for grant request");
   endtask

   task automatic t_sysclk;
      int rises;
      int flips;
      logic d_p;
      logic s_p;
      rises = 0;
      flips = 0;
      d_p = double_freq_clock_in;
      s_p = system_clock_out;
      repeat (120) begin
         tick();
         rises += (double_freq_clock_in === 1'b1 && d_p === 1'b0);
         flips += (system_clock_out !== s_p);
         d_p = double_freq_clock_in;
         s_p = system_clock_out;
      end
      chk(rises >= 19 && flips >= rises - 1 && flips <= rises + 1, "clock not halved");
   endtask

   // =====================================================
   // main sequence
   initial begin
      srst = 1'b1;
      {parity_error_in, channel_error_in, io_write, io_read} = 4'h0;
      io_addr = 16'h0000;
      io_wdata = 8'h00;
      {cycle_done_req, shutdown_cycle, hold_req, local_pull} = 4'h0;
      supply_good_in = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      chk(nmi_out === 1'b0 && rdy_n_oe === 1'b0 && rdy_n_out === 1'b1, "reset values");
      srst = 1'b0;
      reset_pulse(1'b1, "cpu reset after srst");
      t_nmi();
      t_triggers();
      t_ready();
      t_grant();
      t_sysclk();
      test_done();
   end
endmodule
`default_nettype wire
